// >>> core/serial_cfg.svh
`ifndef SERIAL_CFG_SVH
`define SERIAL_CFG_SVH
// index of the last of the 16 samples in a serial bit period
`define OVS_LAST    4'hF
// three vote samples around the middle of a bit
`define VOTE_FIRST  4'h7
`define VOTE_LAST   4'h9
// index of the stop bit in a ten and an eleven bit frame
`define STOP_IDX_10 4'h9
`define STOP_IDX_11 4'hA
// clocks from end of stop bit to done flag, ten bit frame
`define TX_DONE_LAG 2'h2
// divider reload per sample in the fixed-rate mode (4 and 2 clocks per sample), slow and fast
`define FIX_DIV_SLOW 2'h3
`define FIX_DIV_FAST 2'h1
// transmit buffer depth
`define TX_FIFO_DEPTH 16
`endif

// >>> core/serial_pkg.sv
package serial_pkg;
    // timer 2 count rate chosen for the timer block
    typedef enum logic [1:0] {PRE_DIV2, PRE_DIV4, PRE_DIV12} prescale_e;
    typedef enum {TX_IDLE, TX_WAIT, TX_SHIFT, TX_LAG} tx_state_e;
    typedef enum {RX_IDLE, RX_BUSY} rx_state_e;
    // two of three vote
    function automatic logic maj3(input logic [2:0] s);
        return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction : maj3
endpackage : serial_pkg

// >>> core/fifo_if.sv
`timescale 1ns/1ps
interface fifo_if #(parameter int WIDTH = 8);
    logic [WIDTH-1:0] data;  // word
    logic             valid; // word offered
    logic             ready; // word taken
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : fifo_if

// >>> core/serial_fifo.sv
`timescale 1ns/1ps
module serial_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk, // system clock
    input wire logic rst, // sync reset, high
    fifo_if.snk      wr,  // filling side
    fifo_if.src      rd   // draining side
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    logic [WIDTH-1:0] mem [DEPTH];      // storage
    logic [AW-1:0]    wp, next_wp;      // write pointer
    logic [AW-1:0]    rp, next_rp;      // read pointer
    logic [CW-1:0]    cnt, next_cnt;    // words in storage
    logic             outV, next_outV;  // output register full
    logic [WIDTH-1:0] outD, next_outD;  // output register
    logic             push, load;

    assign wr.ready = (cnt != CW'(DEPTH));
    assign rd.valid = outV;
    assign rd.data  = outD;

    // head moves to the output register whenever that slot frees
    always_comb begin
        push      = wr.valid && wr.ready;
        load      = (!outV || rd.ready) && (cnt != '0);
        next_wp   = push ? AW'(wp + 1'b1) : wp;
        next_rp   = load ? AW'(rp + 1'b1) : rp;
        next_cnt  = CW'(cnt + CW'(push) - CW'(load));
        next_outV = load ? 1'b1 : (rd.ready ? 1'b0 : outV);
        next_outD = load ? mem[rp] : outD;
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp] <= wr.data;
        end
        if (rst) begin
            wp   <= '0;
            rp   <= '0;
            cnt  <= '0;
            outV <= 1'b0;
            outD <= '0;
        end else begin
            wp   <= next_wp;
            rp   <= next_rp;
            cnt  <= next_cnt;
            outV <= next_outV;
            outD <= next_outD;
        end
    end
endmodule : serial_fifo

// >>> core/serial_baud.sv
`timescale 1ns/1ps
`include "serial_cfg.svh"
module serial_baud
    import serial_pkg::*;
(
    input  wire logic clk,       // system clock
    input  wire logic rst,       // sync reset, high
    input  wire logic fixedRate, // mode 2 selected
    input  wire logic doubler,   // baud doubler
    input  wire logic txSelT2,   // tx from timer 2
    input  wire logic rxSelT2,   // rx from timer 2
    input  wire logic t1Ovf,     // timer 1 rollover pulse
    input  wire logic t2Ovf,     // timer 2 rollover pulse
    output logic      txTick,    // tx sample enable
    output logic      rxTick     // rx sample enable
);
    logic [1:0] pre, next_pre;   // fixed-rate divider
    logic       half, next_half; // timer 1 halving toggle
    logic       fixTick, t1Tick;

    // outside mode 2, each timer 2 rollover and every second timer 1 rollover (each one with doubler) feed the sixteen-step bit counter
    always_comb begin
        fixTick   = (pre == '0);
        next_pre  = fixTick ? (doubler ? `FIX_DIV_FAST : `FIX_DIV_SLOW)
                            : pre - 2'h1;
        next_half = t1Ovf ? ~half : half;
        t1Tick    = t1Ovf && (doubler || half);
        // timer 2 path ignores the doubler
        txTick = fixedRate ? fixTick : (txSelT2 ? t2Ovf : t1Tick);
        rxTick = fixedRate ? fixTick : (rxSelT2 ? t2Ovf : t1Tick);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pre  <= '0;
            half <= 1'b0;
        end else begin
            pre  <= next_pre;
            half <= next_half;
        end
    end
endmodule : serial_baud

// >>> core/serial_port.sv
`timescale 1ns/1ps
`include "serial_cfg.svh"
// Notes on behaviour
// - mode 1: start, eight data LSB first, stop
// - mode 1: stop bit goes to ninth flag
// - timer rollover clocks the divide-by-16 counter
// - timer 1 rate halved unless doubler set
// - timer 2 baud unaffected by doubler
// - separate timer 2 selects for tx, rx
// - any select: timer 2 counts clock/2
// - any select: no timer 2 flag, trigger ignored
// - tx starts at first counter rollover after write
// - mode 1 tx done two clocks after stop
// - rx starts on falling edge, 16x sampling
// - start edge resets rx divide-by-16 counter
// - each bit is majority of three mid samples
// - start not confirmed low: abandon frame
// - mid stop: accept only if flag clear, filter
// - after mid stop, await next falling edge
// - modes 2, 3: eleven bit frame, ninth bit
// - ninth transmitted bit from tx ninth control
// - mode 2 rate clock/64 or clock/32
// - mode 2 tx done as stop bit driven
// - modes 2, 3: ninth bit into ninth flag
// - mode 3: mode 2 frames, timer baud
// - two mode bits select mode 0 to 3
// - done flags stay until software clears
// - receive only while receive enable set
module serial_port
    import serial_pkg::*;
(
    input  wire logic       clk,                   // 40 MHz clock
    input  wire logic       rst,                   // sync reset, high
    input  wire logic       modeSelectHi,          // mode bit, upper
    input  wire logic       modeSelectLo,          // mode bit, lower
    input  wire logic       multiprocEnable,       // accept filter
    input  wire logic       rxEnable,              // receive enable
    input  wire logic       txNinthBit,            // ninth tx bit
    input  wire logic       baudDoubler,           // rate doubler
    input  wire logic       txClockFromTimer2Sel,  // tx on timer 2
    input  wire logic       rxClockFromTimer2Sel,  // rx on timer 2
    input  wire logic       timer2ClockRateBit,    // 1: clk/4
    input  wire logic       timer1Overflow,        // t1 rollover
    input  wire logic       timer2Overflow,        // t2 rollover
    input  wire logic       timer2ExtTrigger,      // reload pin
    input  wire logic [7:0] txData,                // word to send
    input  wire logic       txValid,               // word offered
    output logic            txReady,               // buffer room
    input  wire logic       txDoneClr,             // clear tx flag
    input  wire logic       rxDoneClr,             // clear rx flag
    output logic [7:0]      serialBuffer,          // received byte
    output logic            rxNinthBit,            // ninth rx bit
    output logic            txDoneFlag,            // tx done flag
    output logic            rxDoneFlag,            // rx done flag
    output prescale_e       timer2Prescale,        // t2 count rate
    output logic            timer2OverflowFlagSet, // set t2 flag
    output logic            timer2ExtTriggerGated, // trigger passed
    input  wire logic       rxd,                   // serial in pin
    output logic            txd                    // serial out pin
);
    // mode decode
    logic       anyAsync;  // modes 1 to 3
    logic       nineBit;   // modes 2 and 3
    logic       isMode1;   // ten bit frame
    logic       anyT2Sel;  // timer 2 drives a direction
    logic [3:0] stopIdx;   // frame position of stop bit

    always_comb begin
        anyAsync = modeSelectHi | modeSelectLo;
        nineBit  = modeSelectHi;
        isMode1  = !modeSelectHi && modeSelectLo;
        anyT2Sel = txClockFromTimer2Sel | rxClockFromTimer2Sel;
        stopIdx  = nineBit ? `STOP_IDX_11 : `STOP_IDX_10;
    end

    // pin synchronisers; only the second stage is looked at
    logic rxMeta, rxSync;  // serial input
    logic trgMeta, trgSync; // reload trigger input

    always_ff @(posedge clk) begin
        if (rst) begin
            rxMeta  <= 1'b1;
            rxSync  <= 1'b1;
            trgMeta <= 1'b0;
            trgSync <= 1'b0;
        end else begin
            rxMeta  <= rxd;
            rxSync  <= rxMeta;
            trgMeta <= timer2ExtTrigger;
            trgSync <= trgMeta;
        end
    end

    // timer 2 hooks: baud use takes over its rate and flag
    always_comb begin
        if (anyT2Sel) begin
            timer2Prescale = PRE_DIV2;
        end else if (timer2ClockRateBit) begin
            timer2Prescale = PRE_DIV4;
        end else begin
            timer2Prescale = PRE_DIV12;
        end
        timer2OverflowFlagSet = timer2Overflow && !anyT2Sel;
        timer2ExtTriggerGated = trgSync && !anyT2Sel;
    end

    // sample enables per direction
    logic txTick; // tx sixteenth-bit enable
    logic rxTick; // rx sixteenth-bit enable

    serial_baud u_baud (
        .clk       (clk),
        .rst       (rst),
        .fixedRate (modeSelectHi && !modeSelectLo),
        .doubler   (baudDoubler),
        .txSelT2   (txClockFromTimer2Sel),
        .rxSelT2   (rxClockFromTimer2Sel),
        .t1Ovf     (timer1Overflow),
        .t2Ovf     (timer2Overflow),
        .txTick    (txTick),
        .rxTick    (rxTick)
    );

    // transmit buffer; a full buffer stalls the writer via txReady
    fifo_if #(.WIDTH(8)) fillSide ();
    fifo_if #(.WIDTH(8)) drainSide ();

    assign fillSide.data  = txData;
    assign fillSide.valid = txValid;
    assign txReady        = fillSide.ready;

    serial_fifo #(.WIDTH(8), .DEPTH(`TX_FIFO_DEPTH)) u_txbuf (
        .clk (clk),
        .rst (rst),
        .wr  (fillSide.snk),
        .rd  (drainSide.src)
    );

    // transmitter
    tx_state_e   txState, next_txState; // tx sequencer
    logic [3:0]  txCnt, next_txCnt;     // free divide-by-16
    logic [3:0]  txIdx, next_txIdx;     // frame position
    logic [10:0] txShift, next_txShift; // frame bits, start first
    logic [1:0]  txLag, next_txLag;     // done delay, ten bit frame
    logic        next_txd;              // line value
    logic        txRoll;                // counter rollover
    logic        txSet;                 // raise tx done

    assign drainSide.ready = (txState == TX_IDLE) && anyAsync;

    // frame is loaded on pop, then waits for a counter rollover
    always_comb begin
        txRoll       = txTick && (txCnt == `OVS_LAST);
        next_txCnt   = txTick ? txCnt + 4'h1 : txCnt;
        next_txState = txState;
        next_txIdx   = txIdx;
        next_txShift = txShift;
        next_txLag   = txLag;
        next_txd     = txd;
        txSet        = 1'b0;
        unique case (txState)
            TX_IDLE: begin
                next_txd = 1'b1;
                if (drainSide.valid && anyAsync) begin
                    // stop, ninth, data LSB first, start
                    next_txShift = {1'b1, txNinthBit,
                                    drainSide.data, 1'b0};
                    next_txState = TX_WAIT;
                end
            end
            TX_WAIT: begin
                if (txRoll) begin
                    next_txd     = txShift[0];
                    next_txIdx   = 4'h0;
                    next_txState = TX_SHIFT;
                end
            end
            TX_SHIFT: begin
                if (txRoll) begin
                    if (txIdx == stopIdx) begin
                        // stop bit has run its full time
                        next_txd = 1'b1;
                        if (isMode1) begin
                            next_txLag   = `TX_DONE_LAG;
                            next_txState = TX_LAG;
                        end else begin
                            next_txState = TX_IDLE;
                        end
                    end else begin
                        next_txIdx = txIdx + 4'h1;
                        // in ten bit frames index 9 is the stop bit
                        next_txd = (txIdx + 4'h1 == stopIdx) ? 1'b1
                                 : txShift[txIdx + 4'h1];
                        // eleven bit frames flag as stop starts
                        txSet = nineBit
                             && (txIdx + 4'h1 == stopIdx);
                    end
                end
            end
            TX_LAG: begin
                next_txd   = 1'b1;
                next_txLag = txLag - 2'h1;
                if (txLag == 2'h1) begin
                    txSet        = 1'b1;
                    next_txState = TX_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            txState <= TX_IDLE;
            txCnt   <= 4'h0;
            txIdx   <= 4'h0;
            txShift <= 11'h7FF;
            txLag   <= 2'h0;
            txd     <= 1'b1;
        end else begin
            txState <= next_txState;
            txCnt   <= next_txCnt;
            txIdx   <= next_txIdx;
            txShift <= next_txShift;
            txLag   <= next_txLag;
            txd     <= next_txd;
        end
    end

    // receiver
    rx_state_e  rxState, next_rxState; // rx sequencer
    logic [3:0] rxCnt, next_rxCnt;     // divide-by-16, edge aligned
    logic [3:0] rxIdx, next_rxIdx;     // frame position
    logic [2:0] votes, next_votes;     // mid-bit samples
    logic [8:0] rxShift, next_rxShift; // data then ninth bit
    logic       rxPrev, next_rxPrev;   // line at last sample
    logic [7:0] next_serialBuffer;
    logic       next_rxNinthBit;
    logic       bitVal;                // voted bit
    logic       voteNow;               // last vote sample
    logic       tagBit;                // bit seen by the filter
    logic       rxSet;                 // frame accepted

    // sampling runs only on rx enables; edge resets the counter
    always_comb begin
        next_rxState      = rxState;
        next_rxCnt        = rxCnt;
        next_rxIdx        = rxIdx;
        next_votes        = votes;
        next_rxShift      = rxShift;
        next_rxPrev       = rxTick ? rxSync : rxPrev;
        next_serialBuffer = serialBuffer;
        next_rxNinthBit   = rxNinthBit;
        voteNow           = rxTick && (rxCnt == `VOTE_LAST);
        bitVal            = maj3({votes[1:0], rxSync});
        // ten bit frames filter on stop, eleven on ninth bit
        tagBit = nineBit ? rxShift[8] : bitVal;
        rxSet  = 1'b0;
        unique case (rxState)
            RX_IDLE: begin
                if (rxTick && rxEnable && anyAsync
                    && rxPrev && !rxSync) begin
                    next_rxCnt   = 4'h1;
                    next_rxIdx   = 4'h0;
                    next_rxState = RX_BUSY;
                end
            end
            RX_BUSY: begin
                if (rxTick) begin
                    next_rxCnt = rxCnt + 4'h1;
                end
                if (rxTick && rxCnt >= `VOTE_FIRST
                    && rxCnt <= `VOTE_LAST) begin
                    next_votes = {votes[1:0], rxSync};
                end
                if (!rxEnable || !anyAsync) begin
                    next_rxState = RX_IDLE;
                end else if (voteNow) begin
                    if (rxIdx == 4'h0) begin
                        if (bitVal) begin
                            next_rxState = RX_IDLE;
                        end
                        next_rxIdx = 4'h1;
                    end else if (rxIdx == stopIdx) begin
                        if (!rxDoneFlag
                            && (!multiprocEnable || tagBit)) begin
                            rxSet = 1'b1;
                            next_serialBuffer = nineBit ? rxShift[7:0]
                                                        : rxShift[8:1];
                            next_rxNinthBit = tagBit;
                        end
                        next_rxState = RX_IDLE;
                    end else begin
                        next_rxShift = {bitVal, rxShift[8:1]};
                        next_rxIdx   = rxIdx + 4'h1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rxState      <= RX_IDLE;
            rxCnt        <= 4'h0;
            rxIdx        <= 4'h0;
            votes        <= 3'h7;
            rxShift      <= 9'h000;
            rxPrev       <= 1'b1;
            serialBuffer <= 8'h00;
            rxNinthBit   <= 1'b0;
        end else begin
            rxState      <= next_rxState;
            rxCnt        <= next_rxCnt;
            rxIdx        <= next_rxIdx;
            votes        <= next_votes;
            rxShift      <= next_rxShift;
            rxPrev       <= next_rxPrev;
            serialBuffer <= next_serialBuffer;
            rxNinthBit   <= next_rxNinthBit;
        end
    end

    // done flags: a set in the clearing cycle wins
    logic next_txDoneFlag, next_rxDoneFlag;

    always_comb begin
        next_txDoneFlag = txSet || (txDoneFlag && !txDoneClr);
        next_rxDoneFlag = rxSet || (rxDoneFlag && !rxDoneClr);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            txDoneFlag <= 1'b0;
            rxDoneFlag <= 1'b0;
        end else begin
            txDoneFlag <= next_txDoneFlag;
            rxDoneFlag <= next_rxDoneFlag;
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_TXD_IDLE_HIGH: assert property (
        txState == TX_IDLE |-> txd)
        else $error("tx line low while idle");
    AST_TX_START_ON_ROLL: assert property (
        txState == TX_WAIT && txRoll |=> txState == TX_SHIFT && !txd)
        else $error("start bit not sent at rollover");
    AST_TX_LAG_TWO: assert property (
        txState == TX_SHIFT && txRoll && txIdx == stopIdx && isMode1
        |=> !txSet ##1 txSet)
        else $error("mode 1 done flag not two clocks late");
    AST_TX_FLAG_AT_STOP: assert property (
        txSet && nineBit |=> txd && txState == TX_SHIFT)
        else $error("eleven bit done flag not at stop");
    AST_TX_STICKY: assert property (
        txDoneFlag && !txDoneClr |=> txDoneFlag)
        else $error("tx done flag dropped by itself");
    AST_RX_STICKY: assert property (
        rxDoneFlag && !rxDoneClr |=> rxDoneFlag)
        else $error("rx done flag dropped by itself");
    AST_RX_OFF: assert property (
        !rxEnable |=> rxState == RX_IDLE)
        else $error("receiving while disabled");
    AST_START_ABORT: assert property (
        rxState == RX_BUSY && rxIdx == 4'h0 && voteNow && bitVal
        |=> rxState == RX_IDLE)
        else $error("false start not abandoned");
    AST_RX_NO_OVERWRITE: assert property (
        rxDoneFlag && !rxDoneClr |=> $stable(serialBuffer))
        else $error("buffer loaded while flag set");
    AST_EDGE_ALIGN: assert property (
        rxState == RX_IDLE ##1 rxState == RX_BUSY |-> rxCnt == 4'h1)
        else $error("rx counter not reset at start edge");
    AST_T2_HOOKS: assert property (
        anyT2Sel |-> timer2Prescale == PRE_DIV2
        && !timer2OverflowFlagSet && !timer2ExtTriggerGated)
        else $error("timer 2 not taken over for baud");

    COV_TX_MODE1: cover property (txSet && isMode1);
    COV_TX_NINE: cover property (txSet && nineBit);
    COV_RX_ACCEPT: cover property (rxSet);
    COV_RX_FILTERED: cover property (
        rxState == RX_BUSY && voteNow && rxIdx == stopIdx && !rxSet);
endmodule : serial_port

// >>> bench/serial_node.sv
`timescale 1ns/1ps
module serial_node (
    input  wire logic clk, // system clock
    input  wire logic txd, // line from port
    output logic      rxd  // line into port
);
    int sendClk = 32; // clocks per bit sent
    int takeClk = 32; // clocks per bit taken
    initial rxd = 1'b1; // line idles high
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : hold
    // start low, n bits lsb first, then a high idle bit
    task automatic send_frame(input logic [9:0] bits, input int n);
        rxd = 1'b0;
        hold(sendClk);
        for (int i = 0; i < n; i++) begin
            rxd = bits[i];
            hold(sendClk);
        end
        rxd = 1'b1;
        hold(sendClk);
    endtask : send_frame
    // dip too short to survive the start vote
    task automatic dip(input int n);
        rxd = 1'b0;
        hold(n);
        rxd = 1'b1;
    endtask : dip
    // bounded wait for a start, then sample mid bit
    task automatic take_frame(input int n, output logic [10:0] got);
        int k;
        k = 0;
        got = 11'h000;
        while (txd !== 1'b0 && k < 9000) begin
            hold(1);
            k++;
        end
        hold(takeClk / 2);
        for (int i = 0; i <= n; i++) begin
            got[i] = txd;
            hold(i < n ? takeClk : takeClk / 2);
        end
    endtask : take_frame
endmodule : serial_node

// >>> bench/serial_port_bench.sv
`timescale 1ns/1ps
module serial_port_bench;
    import serial_pkg::*;
    logic clk = 0, rst = 1, modeSelectHi = 0, modeSelectLo = 1, ovf = 0;
    logic multiprocEnable = 0, rxEnable = 1, txNinthBit = 0;
    logic baudDoubler = 0, txClockFromTimer2Sel = 1;
    logic rxClockFromTimer2Sel = 1, timer2ClockRateBit = 0;
    logic timer2ExtTrigger = 0, txValid = 0, txDoneClr = 0, rxDoneClr = 0;
    logic [7:0] txData = 8'h00, serialBuffer;
    logic txReady, rxd, txd, rxNinthBit, txDoneFlag, rxDoneFlag;
    logic timer2OverflowFlagSet, timer2ExtTriggerGated;
    prescale_e timer2Prescale;
    int n_mismatch = 0, checks_done = 0;
    // both timer inputs share one pulse, high every second clock
    serial_port dut_u (.clk, .rst, .modeSelectHi, .modeSelectLo,
        .multiprocEnable, .rxEnable, .txNinthBit, .baudDoubler,
        .txClockFromTimer2Sel, .rxClockFromTimer2Sel, .timer2ClockRateBit,
        .timer1Overflow(ovf), .timer2Overflow(ovf), .timer2ExtTrigger,
        .txData, .txValid, .txReady, .txDoneClr, .rxDoneClr, .serialBuffer,
        .rxNinthBit, .txDoneFlag, .rxDoneFlag, .timer2Prescale,
        .timer2OverflowFlagSet, .timer2ExtTriggerGated, .rxd, .txd);
    serial_node node_u (.clk, .txd, .rxd);
    always #12.5 clk = ~clk;
    always @(posedge clk) ovf <= ~ovf;
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic chk(input logic [10:0] got, input logic [10:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %0h vs %0h", $time, got, exp);
        end
    endtask : chk
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    task automatic clr();
        txDoneClr = 1;
        rxDoneClr = 1;
        tick(1);
        txDoneClr = 0;
        rxDoneClr = 0;
        tick(1);
    endtask : clr
    // mode, doubler, selects; node rates follow the port's tx and rx
    task automatic cfg(input logic [1:0] m, input logic d, ts, rs,
                       input int tb, rb);
        {modeSelectHi, modeSelectLo} = m;
        baudDoubler = d;
        txClockFromTimer2Sel = ts;
        rxClockFromTimer2Sel = rs;
        node_u.takeClk = tb;
        node_u.sendClk = rb;
        tick(40);
    endtask : cfg
    // one word each way at once; acc says the port must keep its word
    task automatic duplex(input logic [7:0] tb, rb, input logic tag,
                          input int n, input logic acc);
        logic [10:0] got, exp;
        txData = tb;
        txValid = 1;
        tick(1);
        txValid = 0;
        fork
            node_u.send_frame({1'b1, tag, rb}, n);
            node_u.take_frame(n, got);
        join
        tick(4);
        exp = (n == 9) ? {2'b01, tb, 1'b0} : {1'b1, txNinthBit, tb, 1'b0};
        if (n == 9) got[10] = 1'b0;
        chk(got, exp);
        chk(rxDoneFlag, acc);
        if (acc) chk({rxNinthBit, serialBuffer}, {tag, rb});
        chk(txDoneFlag, 1);
        clr();
        chk({txDoneFlag, rxDoneFlag}, 0);
    endtask : duplex
    task automatic t_reset();
        chk({txd, txDoneFlag, rxDoneFlag, txReady}, 4'h9);
        chk(serialBuffer, 8'h00);
    endtask : t_reset
    task automatic t_mode1();
        cfg(2'b01, 0, 1, 1, 32, 32);
        timer2ExtTrigger = 1;
        tick(4);
        chk(timer2Prescale, PRE_DIV2);
        chk({timer2OverflowFlagSet, timer2ExtTriggerGated}, 0);
        duplex(8'h3C, 8'hA5, 1, 9, 1);
        multiprocEnable = 1;
        duplex(8'hC3, 8'h5A, 0, 9, 0);
        multiprocEnable = 0;
        cfg(2'b01, 0, 1, 0, 32, 64);
        duplex(8'h81, 8'h7E, 1, 9, 1);
    endtask : t_mode1
    // timer 2 free for its own use, mode 3 on timer 1
    task automatic t_timers();
        cfg(2'b11, 0, 0, 0, 64, 64);
        for (int r = 0; r < 2; r++) begin
            timer2ClockRateBit = r[0];
            // odd wait so the two looks see both rollover phases
            tick(3);
            chk(timer2Prescale, r ? PRE_DIV4 : PRE_DIV12);
            chk({timer2ExtTriggerGated, timer2OverflowFlagSet}, {1'b1, ovf});
        end
        timer2ExtTrigger = 0;
        txNinthBit = 1;
        duplex(8'h96, 8'h69, 0, 10, 1);
    endtask : t_timers
    task automatic t_mode2();
        for (int d = 0; d < 2; d++) begin
            cfg(2'b10, d[0], 0, 0, 64 >> d, 64 >> d);
            txNinthBit = ~d[0];
            duplex(d ? 8'hA6 : 8'h5A, d ? 8'h0F : 8'hF0, d[0], 10, 1);
        end
        multiprocEnable = 1;
        duplex(8'h01, 8'h22, 0, 10, 0);
        duplex(8'h02, 8'h33, 1, 10, 1);
        multiprocEnable = 0;
        node_u.send_frame({2'b11, 8'h44}, 10);
        node_u.send_frame({2'b11, 8'h55}, 10);
        chk({rxDoneFlag, serialBuffer}, {1'b1, 8'h44});
        clr();
    endtask : t_mode2
    task automatic t_noise();
        cfg(2'b01, 0, 1, 1, 32, 32);
        node_u.dip(4);
        tick(64);
        chk(rxDoneFlag, 0);
        rxEnable = 0;
        duplex(8'h11, 8'h99, 1, 9, 0);
        rxEnable = 1;
        duplex(8'h12, 8'h98, 1, 9, 1);
    endtask : t_noise
    // mode 0 holds the sender while the buffer fills until refused;
    // the node is then listening before the first start bit leaves
    task automatic t_fifo();
        int k;
        logic [10:0] got;
        cfg(2'b00, 1, 0, 0, 32, 32);
        k = 0;
        txValid = 1;
        while (txReady === 1'b1 && k < 24) begin
            txData = k[7:0];
            tick(1);
            k++;
        end
        txData = 8'hEE;
        tick(2);
        txValid = 0;
        chk(k, 17);
        chk({txd, txReady}, 2'b10);
        {modeSelectHi, modeSelectLo} = 2'b10;
        for (int i = 0; i < k; i++) begin
            node_u.take_frame(10, got);
            chk(got[8:1], i[7:0]);
        end
        tick(400);
        chk({txd, txReady}, 2'b11);
    endtask : t_fifo
    initial begin
        tick(5);
        rst = 0;
        tick(2);
        t_reset();
        t_mode1();
        t_timers();
        t_mode2();
        t_noise();
        t_fifo();
        test_done();
    end
    // about twice the expected run
    initial begin
        #750000;
        n_mismatch++;
        test_done();
    end
endmodule : serial_port_bench
